// ### rtl/aesec_engine.sv
// Control, status and state storage of the on-chip cipher engine.
// Assumes one-byte accesses from the serial front end, one per cycle at most,
// and burst_end marking the end of a serial frame-buffer transaction.
//
// Overview of operation
// [RULE_01] Control access while running sets error
// [RULE_02] Short state read sets error
// [RULE_03] Status bit 7 shows engine error
// [RULE_04] Status bit 0 shows operation done
// [RULE_05] Control access while running aborts operation
// [RULE_06] Host polls done, avoids control while busy
// [RULE_07] Write-only start bit launches operation
// [RULE_08] Mode field selects codebook, key, chaining
// [RULE_09] Bit 3 selects encrypt or decrypt
// [RULE_10] Byte 0x94 mirrors the control byte
// [RULE_11] Alias write with start bit starts operation
// [RULE_12] Done within 24 us of start
// [RULE_13] Sixteen bytes hold key or state
// [RULE_14] Burst writes return previous byte content
// [RULE_15] New start clears done until completion
`timescale 1ns/1ps
`include "aesec_params.svh"

module aesec_engine #(
  parameter int unsigned RUN_CYCLES = `AESEC_RUN_CYCLES
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Byte access and transaction framing
  input  wire aesec_pkg::aesec_access_s acc,
  input  wire logic                  burst_end,
  // Read data and status outputs
  output logic [7:0]                 rdata,
  output logic                       busy,
  output logic                       run_start,
  output logic [2:0]                 run_mode,
  output logic                       run_dir
);
  import aesec_pkg::*;

  localparam int unsigned CW = $clog2(RUN_CYCLES + 1);

  aesec_state_e     state_reg, state_next;
  logic [CW-1:0]    cnt_reg, cnt_next;
  logic             err_reg, err_next;
  logic [7:0]       ctrl_reg, ctrl_next;
  logic [7:0]       rdata_reg, rdata_next;
  logic             start_reg, start_next;
  logic [15:0]      rd_seen_reg, rd_seen_next;
  logic [7:0]       mem_reg [`AESEC_STATE_BYTES];
  logic             ctrl_hit, state_hit, go, abort;
  logic [3:0]       idx;
  logic             busy_reg, busy_next;
  logic [CW-1:0]    run_age_reg, run_age_next;

  assign ctrl_hit  = (acc.wr | acc.rd) &&
                     (acc.addr == `AESEC_ADDR_CONTROL || acc.addr == `AESEC_ADDR_ALIAS); // RULE_10
  assign state_hit = acc.addr >= `AESEC_ADDR_STATE_LO && acc.addr <= `AESEC_ADDR_STATE_HI;
  assign idx       = 4'(acc.addr - `AESEC_ADDR_STATE_LO);
  assign abort     = ctrl_hit && state_reg == AESEC_RUN; // RULE_05
  assign go        = acc.wr && !abort && acc.wdata[`AESEC_BIT_START] &&
                     (acc.addr == `AESEC_ADDR_CONTROL || acc.addr == `AESEC_ADDR_ALIAS); // RULE_07 RULE_11

  always_comb begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    err_next     = err_reg;
    ctrl_next    = ctrl_reg;
    start_next   = 1'b0;
    rd_seen_next = rd_seen_reg;
    if (abort) begin
      state_next = AESEC_IDLE;
      err_next   = 1'b1; // RULE_01
    end else if (go) begin
      state_next   = AESEC_RUN;
      cnt_next     = CW'(RUN_CYCLES - 1);
      start_next   = 1'b1;
      err_next     = 1'b0;
      rd_seen_next = '0;
    end else begin
      case (state_reg)
        AESEC_IDLE: begin
        end
        AESEC_RUN: begin
          if (cnt_reg == '0) begin
            state_next = AESEC_DONE; // RULE_12
          end else begin
            cnt_next = cnt_reg - 1'b1;
          end
        end
        AESEC_DONE: begin
        end
        default: begin
          state_next = AESEC_IDLE;
        end
      endcase
    end
    if (acc.wr && !abort &&
        (acc.addr == `AESEC_ADDR_CONTROL || acc.addr == `AESEC_ADDR_ALIAS)) begin
      ctrl_next = acc.wdata & `AESEC_CTRL_MASK; // RULE_08 RULE_09
    end
    if (acc.rd && state_hit && state_reg == AESEC_DONE) begin
      rd_seen_next[idx] = 1'b1;
    end
    // Partial readout of a finished block counts as an engine error
    // Set wins over a start that lands in the same cycle
    if (burst_end && state_reg == AESEC_DONE && rd_seen_reg != '0 &&
        rd_seen_reg != '1) begin
      err_next     = 1'b1; // RULE_02
      rd_seen_next = '0;
    end else if (burst_end && !go) begin
      rd_seen_next = '0;
    end
    busy_next = state_next == AESEC_RUN;
  end

  // Read path: previous location content leaves one byte later
  always_comb begin
    rdata_next = rdata_reg;
    if (acc.wr || acc.rd) begin
      if (acc.addr == `AESEC_ADDR_STATUS) begin
        rdata_next = {err_reg, 6'h00, state_reg == AESEC_DONE}; // RULE_03 RULE_04 RULE_15
      end else if (acc.addr == `AESEC_ADDR_CONTROL || acc.addr == `AESEC_ADDR_ALIAS) begin
        rdata_next = ctrl_reg;
      end else if (state_hit) begin
        rdata_next = mem_reg[idx]; // RULE_14 RULE_13
      end else begin
        rdata_next = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg   <= AESEC_IDLE;
      cnt_reg     <= '0;
      err_reg     <= 1'b0;
      ctrl_reg    <= `AESEC_CTRL_RESET;
      rdata_reg   <= 8'h00;
      start_reg   <= 1'b0;
      rd_seen_reg <= '0;
      busy_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      err_reg     <= err_next;
      ctrl_reg    <= ctrl_next;
      rdata_reg   <= rdata_next;
      start_reg   <= start_next;
      rd_seen_reg <= rd_seen_next;
      busy_reg    <= busy_next;
    end
  end

  // Age of a run, kept apart from the down-counter to check its bound
  always_comb begin
    run_age_next = '0;
    if (state_reg == AESEC_RUN && state_next == AESEC_RUN) begin
      run_age_next = run_age_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_age_reg <= '0;
    end else begin
      run_age_reg <= run_age_next;
    end
  end

  // Key or state bytes; the cipher core itself lies outside
  for (genvar g = 0; g < `AESEC_STATE_BYTES; g++) begin : g_mem
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        mem_reg[g] <= 8'h00;
      end else if (acc.wr && state_hit && idx == 4'(g)) begin
        mem_reg[g] <= acc.wdata; // RULE_13
      end
    end
  end

  assign rdata     = rdata_reg;
  assign busy      = busy_reg;
  assign run_start = start_reg;
  assign run_mode  = ctrl_reg[6:4];
  assign run_dir   = ctrl_reg[`AESEC_BIT_DIR];

  chk_done_bound: assert property (@(posedge clk) disable iff (rst) // RULE_12
    state_reg == AESEC_RUN |-> run_age_reg < RUN_CYCLES)
    else $error("done not reached in time");
  chk_run_exit: assert property (@(posedge clk) disable iff (rst) // RULE_12
    state_reg == AESEC_RUN && !ctrl_hit ##1 state_reg != AESEC_RUN
    |-> state_reg == AESEC_DONE)
    else $error("run ended without done");
  chk_start_pulse: assert property (@(posedge clk) disable iff (rst) // RULE_07
    run_start |=> !run_start && busy)
    else $error("start pulse too long");
  chk_abort_err: assert property (@(posedge clk) disable iff (rst) // RULE_01
    abort |=> err_reg && state_reg == AESEC_IDLE)
    else $error("abort did not flag error");
  chk_start_clr: assert property (@(posedge clk) disable iff (rst) // RULE_15
    go |=> state_reg == AESEC_RUN && !start_reg == 1'b0)
    else $error("start did not clear done");
  chk_status_rd: assert property (@(posedge clk) disable iff (rst) // RULE_04
    acc.rd && acc.addr == `AESEC_ADDR_STATUS |=> rdata_reg[0] == $past(state_reg == AESEC_DONE))
    else $error("status done bit wrong");
  chk_err_bit: assert property (@(posedge clk) disable iff (rst) // RULE_03
    acc.rd && acc.addr == `AESEC_ADDR_STATUS |=> rdata_reg[7] == $past(err_reg))
    else $error("status error bit wrong");
  chk_alias_wr: assert property (@(posedge clk) disable iff (rst) // RULE_10
    acc.wr && acc.addr == `AESEC_ADDR_ALIAS && !abort |=> ctrl_reg == (
    $past(acc.wdata) & `AESEC_CTRL_MASK))
    else $error("alias write not mirrored");
  chk_ctrl_wo: assert property (@(posedge clk) disable iff (rst) // RULE_07
    ctrl_reg[`AESEC_BIT_START] == 1'b0)
    else $error("start bit stored");
  chk_short_rd: assert property (@(posedge clk) disable iff (rst) // RULE_02
    burst_end && state_reg == AESEC_DONE && rd_seen_reg != '0 && rd_seen_reg != '1
    |=> err_reg)
    else $error("short read not flagged");
  chk_echo: assert property (@(posedge clk) disable iff (rst) // RULE_14
    acc.wr && state_hit && state_reg != AESEC_RUN |=> rdata_reg == $past(mem_reg[idx]))
    else $error("previous byte not returned");

  cov_start: cover property (@(posedge clk) disable iff (rst) go);
  cov_abort: cover property (@(posedge clk) disable iff (rst) abort);
  cov_done:  cover property (@(posedge clk) disable iff (rst) $rose(state_reg == AESEC_DONE));
  cov_short: cover property (@(posedge clk) disable iff (rst) burst_end && !err_reg ##1 err_reg);
  cov_alias: cover property (@(posedge clk) disable iff (rst)
    go && acc.addr == `AESEC_ADDR_ALIAS);

endmodule : aesec_engine

// ### rtl/aesec_params.svh
// Constants for the cipher engine control and status block.
// Assumes inclusion by the package and the engine module only.
`ifndef AESEC_PARAMS_SVH
`define AESEC_PARAMS_SVH

`define AESEC_ADDR_STATUS     8'h82
`define AESEC_ADDR_CONTROL    8'h83
`define AESEC_ADDR_STATE_LO   8'h84
`define AESEC_ADDR_STATE_HI   8'h93
`define AESEC_ADDR_ALIAS      8'h94
`define AESEC_BIT_ERROR       7
`define AESEC_BIT_DONE        0
`define AESEC_BIT_START       7
`define AESEC_BIT_DIR         3
`define AESEC_CTRL_MASK       8'h78
`define AESEC_CTRL_RESET      8'h00
`define AESEC_STATE_BYTES     16
`define AESEC_T_DONE_NS       24000
`define AESEC_CLK_NS          20
`define AESEC_RUN_CYCLES      ((`AESEC_T_DONE_NS) / (`AESEC_CLK_NS))

`endif

// ### rtl/aesec_pkg.sv
// Types shared by the cipher engine control block.
// Assumes the constants header sits beside it.
`include "aesec_params.svh"
package aesec_pkg;

  typedef enum logic [2:0] {
    AESEC_MODE_ECB = 3'h0,
    AESEC_MODE_KEY = 3'h1,
    AESEC_MODE_CBC = 3'h2
  } aesec_mode_e;

  typedef enum logic [1:0] {
    AESEC_IDLE = 2'h0,
    AESEC_RUN  = 2'h1,
    AESEC_DONE = 2'h3
  } aesec_state_e;

  // One byte access from the serial frame-buffer front end
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } aesec_access_s;

  typedef struct packed {
    logic       start;
    logic [2:0] mode;
    logic       dir;
    logic [2:0] rsvd;
  } aesec_ctrl_s;

endpackage : aesec_pkg

// ### sim/aesec_host.sv
// Host model issuing byte accesses to the engine.
// Assumes the engine samples strobes on the rising edge.
`timescale 1ns/1ps
module aesec_host (
  // Clock
  input  wire logic                clk,
  // Access towards engine
  output aesec_pkg::aesec_access_s acc,
  output logic                     burst_end,
  // Read data back
  input  wire logic [7:0]          rdata
);
  import aesec_pkg::*;
  logic [7:0] rd_val;
  initial begin
    acc = '0;
    burst_end = 1'b0;
  end
  // One access, then idle lines inverted so stale values never pass
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    acc <= '{wr, !wr, a, d};
    @(negedge clk);
    rd_val = rdata;
    acc <= '{1'b0, 1'b0, ~a, ~d};
  endtask : xfer
  task automatic frame_end();
    @(negedge clk);
    burst_end <= 1'b1;
    @(negedge clk);
    burst_end <= 1'b0;
  endtask : frame_end
endmodule : aesec_host

// ### sim/test_aesec_engine.sv
// Self-checking bench for the cipher engine control block.
// Assumes the host model and a shortened run count.
`timescale 1ns/1ps
module test_aesec_engine;
  import aesec_pkg::*;
  localparam int RUN = 8;
  logic          clk = 1'b0;
  logic          rst = 1'b1;
  aesec_access_s acc;
  logic          burst_end, busy, run_start, run_dir;
  logic [7:0]    rdata;
  logic [2:0]    run_mode;
  int            err_total = 0;
  int            check_count = 0;
  // Rows: address, control byte, mode, direction
  localparam logic [19:0] ROWS [4] = '{{8'h83, 8'h80, 3'h0, 1'b0},
    {8'h94, 8'h90, 3'h1, 1'b0}, {8'h83, 8'ha0, 3'h2, 1'b0}, {8'h94, 8'h88, 3'h0, 1'b1}};
  always #10 clk = ~clk;
  aesec_engine #(.RUN_CYCLES(RUN)) u_aesec_engine (.clk(clk), .rst(rst), .acc(acc),
    .burst_end(burst_end), .rdata(rdata), .busy(busy), .run_start(run_start),
    .run_mode(run_mode), .run_dir(run_dir));
  aesec_host u_aesec_host (.clk(clk), .acc(acc), .burst_end(burst_end), .rdata(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string s);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string s);
    u_aesec_host.xfer(1'b0, a, 8'h00);
    chk(u_aesec_host.rd_val, exp, s);
  endtask : rd
  // Start, check done cleared, wait bounded for completion
  task automatic run_op(input logic [7:0] a, input logic [7:0] c);
    int n = 0;
    u_aesec_host.xfer(1'b1, a, c);
    chk({6'h0, busy, run_start}, 8'h03, "start");
    rd(8'h82, 8'h00, "busy status");
    while (busy === 1'b1 && n < RUN + 4) begin
      @(negedge clk);
      n++;
    end
    if (n >= RUN + 4) begin
      err_total++;
      wrap_up();
    end
    chk(8'(n), 8'(RUN - 2), "latency");
    rd(8'h82, 8'h01, "done");
  endtask : run_op
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk({rdata[3:0], busy, run_start, run_dir, |run_mode}, 8'h00, "reset");
    rd(8'h83, 8'h00, "ctrl reset");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      run_op(ROWS[i][19:12], ROWS[i][11:4]);
      chk({4'h0, run_mode, run_dir}, {4'h0, ROWS[i][3:0]}, "mode");
    end
    $display("test rows done");
    rd(8'h83, 8'h08, "ctrl read");
    rd(8'h94, 8'h08, "alias read");
    u_aesec_host.xfer(1'b1, 8'h84, 8'h5a);
    u_aesec_host.xfer(1'b1, 8'h84, 8'ha5);
    chk(u_aesec_host.rd_val, 8'h5a, "shift out");
    u_aesec_host.frame_end();
    $display("test burst done");
    rd(8'h84, 8'ha5, "state");
    rd(8'h85, 8'h00, "state");
    u_aesec_host.frame_end();
    rd(8'h82, 8'h81, "short read");
    $display("test short read done");
    u_aesec_host.xfer(1'b1, 8'h83, 8'h80);
    u_aesec_host.xfer(1'b0, 8'h83, 8'h00);
    chk({7'h0, busy}, 8'h00, "abort");
    rd(8'h82, 8'h80, "abort err");
    $display("test abort done");
    u_aesec_host.xfer(1'b1, 8'h94, 8'h80);
    chk({6'h0, busy, run_start}, 8'h03, "restart");
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({rdata[3:0], busy, run_start, run_dir, |run_mode}, 8'h00, "mid reset");
    rd(8'h82, 8'h00, "reset status");
    $display("test mid reset done");
    wrap_up();
  end
endmodule : test_aesec_engine
